/* File: shared/nv_port_pkg.sv */
// Constants, register map and timing for the nonvolatile byte access port
package nv_port_pkg;
   // Store geometry
   localparam int NV_DEPTH = 1024;
   localparam int NV_ADDR_W = 10;
   localparam int NV_DATA_W = 8;
   // I/O register addresses (6-bit I/O space)
   localparam logic [5:0] IO_ADDR_HIGH = 6'h13;
   localparam logic [5:0] IO_ADDR_LOW = 6'h12;
   localparam logic [5:0] IO_DATA = 6'h11;
   localparam logic [5:0] IO_CTRL = 6'h10;
   // Control register fields
   localparam int CTRL_ARM_BIT = 2;
   localparam int CTRL_WRITE_BIT = 1;
   localparam int CTRL_READ_BIT = 0;
   // Reset values
   localparam logic [9:0] ADDR_RESET = 10'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Clocking and timing
   localparam int SYS_CLK_HZ = 20_000_000;
   localparam int OSC_HZ = 1_000_000;
   localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ;
   localparam int WRITE_OSC_CYCLES = 8448;
   localparam logic [2:0] ARM_WINDOW = 3'h4;
   localparam logic [2:0] READ_HALT = 3'h4;
   localparam logic [2:0] WRITE_HALT = 3'h2;
   // Write engine states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WRITE = 2'b10
   } wr_state_t;
endpackage : nv_port_pkg

/* File: hdl/nv_cell_array.sv */
// Flip-flop byte array with one write port and a combinational read port
`timescale 1ns/1ps
module nv_cell_array
   import nv_port_pkg::*;
#(
   parameter int DEPTH = NV_DEPTH,
   parameter int ADDR_W = NV_ADDR_W,
   parameter int DATA_W = NV_DATA_W
) (
   // Clock
   input wire logic sys_clk,
   // Write port
   input wire logic we,
   input wire logic [ADDR_W-1:0] waddr,
   input wire logic [DATA_W-1:0] wdata,
   // Read port
   input wire logic [ADDR_W-1:0] raddr,
   output logic [DATA_W-1:0] rdata
);
   logic [DATA_W-1:0] cells [DEPTH];

   // Contents are not reset: they model retained storage
   always_ff @(posedge sys_clk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   // Read is immediate so a fetch completes within one access
   assign rdata = cells[raddr];
endmodule : nv_cell_array

/* File: hdl/nv_byte_port.sv */
// I/O-mapped access port to the nonvolatile data byte store
// Summary of operation
// - Store holds 1024 bytes in its own space, one byte per access.
// - Address, data and control registers sit in the processor I/O space.
// - Writes are self-timed; write strobe reads one until the store is ready.
// - A read stalls the processor four cycles.
// - A write start stalls the processor two cycles.
// - Address bits 15 to 10 are reserved and read as zero.
// - Address bits 9 to 0 pick the byte, linearly 0 to 1023.
// - On a write the data register supplies the stored byte.
// - On a read the fetched byte lands in the data register.
// - The arm bit clears itself four cycles after being set.
// - The strobe starts a write only while arm is still set.
// - Strobe clears when write completes, after 8448 oscillator cycles.
// - A read strobe fetches the byte at once while no write runs, usable next instruction.
`timescale 1ns/1ps
module nv_byte_port
   import nv_port_pkg::*;
#(
   parameter int WRITE_TICKS = WRITE_OSC_CYCLES,
   parameter int CLK_PER_TICK = OSC_DIV
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // I/O register port
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // Processor stall
   output logic cpu_halt
);
   wr_state_t state, next_state;
   logic [NV_ADDR_W-1:0] nv_address_pair, next_address_pair;
   logic [NV_DATA_W-1:0] nv_data_byte, next_data_byte;
   logic [2:0] arm_cnt, next_arm_cnt;
   logic [2:0] halt_cnt, next_halt_cnt;
   logic [7:0] rdata_q, next_rdata;
   logic [15:0] div_cnt, next_div_cnt;
   logic [15:0] tick_cnt, next_tick_cnt;
   logic [NV_ADDR_W-1:0] wr_addr, next_wr_addr;
   logic [NV_DATA_W-1:0] wr_data, next_wr_data;
   logic master_write_arm;
   logic write_strobe;
   logic ctrl_wr;
   logic arm_request;
   logic write_start;
   logic read_go;
   logic osc_tick;
   logic write_done;
   logic [NV_DATA_W-1:0] array_rdata;

   // Register hit test shared by the write decode and the read-back mux
   function automatic logic hit(input logic [5:0] a, input logic [5:0] reg_addr);
      hit = (a == reg_addr);
   endfunction : hit

   // Status bits derived from state
   assign master_write_arm = (arm_cnt != 3'h0);
   assign write_strobe = (state == ST_WRITE);
   assign ctrl_wr = io_wr && hit(io_addr, IO_CTRL);
   assign arm_request = ctrl_wr && io_wdata[CTRL_ARM_BIT];
   // Arm must already be set; arm and strobe in one write is refused
   assign write_start = ctrl_wr && io_wdata[CTRL_WRITE_BIT] && master_write_arm
      && (state == ST_IDLE);
   // Write takes priority over a read strobe in the same control write
   assign read_go = ctrl_wr && io_wdata[CTRL_READ_BIT] && (state == ST_IDLE)
      && !write_start;
   assign osc_tick = (div_cnt == 16'(CLK_PER_TICK - 1));
   assign write_done = write_strobe && osc_tick && (tick_cnt == 16'(WRITE_TICKS - 1));
   assign cpu_halt = (halt_cnt != 3'h0);
   assign io_rdata = rdata_q;

   // Storage array, one byte per access
   nv_cell_array #(
      .DEPTH(NV_DEPTH),
      .ADDR_W(NV_ADDR_W),
      .DATA_W(NV_DATA_W)
   ) u_cells (
      .sys_clk(sys_clk),
      .we(write_done),
      .waddr(wr_addr),
      .wdata(wr_data),
      .raddr(nv_address_pair),
      .rdata(array_rdata)
   );

   // Address and data registers
   always_comb begin
      next_address_pair = nv_address_pair;
      next_data_byte = nv_data_byte;
      // Address is frozen while a write runs so the pending byte stays put
      if (io_wr && hit(io_addr, IO_ADDR_HIGH) && (state == ST_IDLE)) begin
         next_address_pair[NV_ADDR_W-1:8] = io_wdata[NV_ADDR_W-9:0];
      end else if (io_wr && hit(io_addr, IO_ADDR_LOW) && (state == ST_IDLE)) begin
         next_address_pair[7:0] = io_wdata;
      end
      if (read_go) begin
         next_data_byte = array_rdata;
      end else if (io_wr && hit(io_addr, IO_DATA)) begin
         next_data_byte = io_wdata;
      end
   end

   // Arm window: a fresh arm write wins over the expiry in the same cycle
   always_comb begin
      next_arm_cnt = arm_cnt;
      if (arm_request) begin
         next_arm_cnt = ARM_WINDOW;
      end else if (arm_cnt != 3'h0) begin
         next_arm_cnt = arm_cnt - 3'h1;
      end
   end

   // Processor stall counter
   always_comb begin
      next_halt_cnt = halt_cnt;
      if (read_go) begin
         next_halt_cnt = READ_HALT;
      end else if (write_start) begin
         next_halt_cnt = WRITE_HALT;
      end else if (halt_cnt != 3'h0) begin
         next_halt_cnt = halt_cnt - 3'h1;
      end
   end

   // Write engine, timed by the divided oscillator tick
   always_comb begin
      next_state = state;
      next_div_cnt = div_cnt;
      next_tick_cnt = tick_cnt;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      case (state)
         ST_IDLE: begin
            next_div_cnt = 16'h0000;
            next_tick_cnt = 16'h0000;
            if (write_start) begin
               // Latch the byte so later data writes cannot corrupt it
               next_wr_addr = nv_address_pair;
               next_wr_data = nv_data_byte;
               next_state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            next_div_cnt = osc_tick ? 16'h0000 : div_cnt + 16'h0001;
            if (osc_tick) begin
               next_tick_cnt = tick_cnt + 16'h0001;
            end
            if (write_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Read-back mux, registered one cycle after the read
   always_comb begin
      next_rdata = rdata_q;
      if (io_rd) begin
         if (hit(io_addr, IO_ADDR_HIGH)) begin
            next_rdata = {6'h00, nv_address_pair[NV_ADDR_W-1:8]};
         end else if (hit(io_addr, IO_ADDR_LOW)) begin
            next_rdata = nv_address_pair[7:0];
         end else if (hit(io_addr, IO_DATA)) begin
            next_rdata = nv_data_byte;
         end else if (hit(io_addr, IO_CTRL)) begin
            // Read strobe self-clears, so it always reads zero
            next_rdata = {5'h00, master_write_arm, write_strobe, 1'b0};
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   // Address and data registers; cleared at reset so software never sees junk
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         nv_address_pair <= ADDR_RESET;
         nv_data_byte <= DATA_RESET;
      end else begin
         nv_address_pair <= next_address_pair;
         nv_data_byte <= next_data_byte;
      end
   end

   // Arm window register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         arm_cnt <= 3'h0;
      end else begin
         arm_cnt <= next_arm_cnt;
      end
   end

   // Stall counter register
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         halt_cnt <= 3'h0;
      end else begin
         halt_cnt <= next_halt_cnt;
      end
   end

   // Write engine registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         div_cnt <= 16'h0000;
         tick_cnt <= 16'h0000;
         wr_addr <= ADDR_RESET;
         wr_data <= DATA_RESET;
      end else begin
         state <= next_state;
         div_cnt <= next_div_cnt;
         tick_cnt <= next_tick_cnt;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
      end
   end

   // Read-back register; holds until the next read
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= next_rdata;
      end
   end

   // Helper: cycles spent in the running write, read only by the length check
   logic [31:0] busy_cycles, next_busy_cycles;
   always_comb begin
      next_busy_cycles = 32'h0000_0000;
      if (state == ST_WRITE) begin
         next_busy_cycles = busy_cycles + 32'h0000_0001;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_cycles <= 32'h0000_0000;
      end else begin
         busy_cycles <= next_busy_cycles;
      end
   end

   // Checks on the arm window, stalls, writes and reads
   arm_window_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      arm_request |=> master_write_arm[*4])
      else $error("arm bit did not stay set four cycles");
   arm_expire_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (arm_cnt == 3'h1) && !arm_request |=> !master_write_arm)
      else $error("arm bit did not clear on time");
   start_guard_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(write_strobe) |-> $past(master_write_arm) && $past(ctrl_wr))
      else $error("write started without arm");
   write_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_start |=> cpu_halt[*2] ##1 !cpu_halt)
      else $error("write stall not two cycles");
   read_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      read_go |=> cpu_halt[*4] ##1 !cpu_halt)
      else $error("read stall not four cycles");
   read_fetch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      read_go |=> nv_data_byte == $past(array_rdata))
      else $error("read byte not loaded");
   addr_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_strobe |=> $stable(nv_address_pair))
      else $error("address changed during write");
   busy_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_strobe && ctrl_wr |=> $stable(nv_data_byte))
      else $error("read accepted during write");
   write_done_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_done |=> !write_strobe && (u_cells.cells[$past(wr_addr)] == $past(wr_data)))
      else $error("write completion wrong");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      io_rd && hit(io_addr, IO_ADDR_HIGH) |=> io_rdata[7:2] == 6'h00)
      else $error("reserved address bits not zero");
   arm_refused_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ctrl_wr && io_wdata[CTRL_WRITE_BIT] && !master_write_arm && (state == ST_IDLE)
      |=> !write_strobe)
      else $error("write started without arm");
   write_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_start |=> (wr_addr == $past(nv_address_pair)) && (wr_data == $past(nv_data_byte)))
      else $error("write byte not latched");
   write_length_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_done |-> busy_cycles == 32'(WRITE_TICKS * CLK_PER_TICK - 1))
      else $error("write time wrong");
   ctrl_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      io_rd && hit(io_addr, IO_CTRL) |=> (io_rdata[7:3] == 5'h00) && !io_rdata[CTRL_READ_BIT]
      && (io_rdata[CTRL_WRITE_BIT] == $past(write_strobe)))
      else $error("control read-back wrong");
   data_read_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      io_rd && hit(io_addr, IO_DATA) |=> io_rdata == $past(nv_data_byte))
      else $error("data read-back wrong");
   halt_source_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      !cpu_halt && !read_go && !write_start |=> !cpu_halt)
      else $error("stall without an access");
   low_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      io_wr && hit(io_addr, IO_ADDR_LOW) && (state == ST_IDLE)
      |=> nv_address_pair[7:0] == $past(io_wdata))
      else $error("address low byte not loaded");
   strobe_busy_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
      write_strobe && ctrl_wr |=> $stable(wr_addr) && $stable(wr_data))
      else $error("second strobe disturbed write");
endmodule : nv_byte_port

/* File: tb/cpu_io_model.sv */
// Processor-side model that drives the I/O register port of the byte store
`timescale 1ns/1ps
module cpu_io_model
   import nv_port_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // I/O register port
   output logic [5:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   // Stall from the port
   input wire logic cpu_halt
);
   // Idle values; released lines show the inverse so stale data never passes
   initial begin
      io_addr = 6'h3f;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h5a;
   end
   // A stalled core issues nothing; checked mid-cycle to stay clear of the edge
   task automatic wait_run();
      int n;
      n = 0;
      @(negedge sys_clk);
      while (cpu_halt !== 1'b0 && n < 64) begin
         @(negedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
   endtask : wait_run
   // One-cycle register write, released at the edge that takes it
   task automatic io_write(input logic [5:0] a, input logic [7:0] d);
      wait_run();
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge sys_clk);
      io_wr <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask : io_write
   // One-cycle register read; data is registered at the taking edge
   task automatic io_read(input logic [5:0] a, output logic [7:0] d);
      wait_run();
      io_addr <= a;
      io_rd <= 1'b1;
      @(posedge sys_clk);
      io_rd <= 1'b0;
      io_addr <= ~a;
      #1 d = io_rdata;
   endtask : io_read
   // Guarded store: address and data first, then arm, then strobe in the window
   task automatic store_byte(input logic [9:0] a, input logic [7:0] d);
      io_write(IO_ADDR_HIGH, {6'h00, a[9:8]});
      io_write(IO_ADDR_LOW, a[7:0]);
      io_write(IO_DATA, d);
      io_write(IO_CTRL, 8'h01 << CTRL_ARM_BIT);
      io_write(IO_CTRL, 8'h01 << CTRL_WRITE_BIT);
   endtask : store_byte
endmodule : cpu_io_model

/* File: tb/eeprom_byte_access_port_tb.sv */
// Self-checking bench for the nonvolatile byte access port
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module eeprom_byte_access_port_tb;
   import nv_port_pkg::*;
   logic sys_clk;
   logic rst_b;
   logic [5:0] io_addr;
   logic io_wr;
   logic io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic cpu_halt;
   logic [7:0] d;
   int n;
   int err_count = 0;
   int total_checks = 0;
   // Short write time keeps the run small: 8 ticks of 4 clocks
   nv_byte_port #(.WRITE_TICKS(8), .CLK_PER_TICK(4)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .cpu_halt(cpu_halt));
   cpu_io_model cpu (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_halt(cpu_halt));
   // 50 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // Count stalled cycles after the edge that took the strobe
   task automatic halt_cycles(output int c);
      c = 0;
      repeat (8) begin
         #1 if (cpu_halt === 1'b1) c++;
         @(posedge sys_clk);
      end
   endtask : halt_cycles
   // Poll busy under a bound; running out counts as a mismatch
   task automatic wait_idle();
      int k;
      k = 0;
      d = 8'hff;
      while (d[CTRL_WRITE_BIT] !== 1'b0 && k < 40) begin
         cpu.io_read(IO_CTRL, d);
         k++;
      end
      `CHK(d[CTRL_WRITE_BIT], 1'b0)
   endtask : wait_idle
   task automatic t_reset();
      logic [5:0] a [5] = '{IO_ADDR_HIGH, IO_ADDR_LOW, IO_DATA, IO_CTRL, 6'h20};
      foreach (a[i]) begin
         cpu.io_read(a[i], d);
         `CHK(d, 8'h00)
      end
      $display("test reset done");
   endtask : t_reset
   task automatic t_addr_bits();
      cpu.io_write(IO_ADDR_HIGH, 8'hff);
      cpu.io_write(IO_ADDR_LOW, 8'hff);
      cpu.io_read(IO_ADDR_HIGH, d);
      `CHK(d, 8'h03)
      cpu.io_read(IO_ADDR_LOW, d);
      `CHK(d, 8'hff)
      $display("test address bits done");
   endtask : t_addr_bits
   task automatic t_write_read();
      logic [9:0] a [2] = '{10'h3ff, 10'h000};
      logic [7:0] v [2] = '{8'ha5, 8'h5c};
      foreach (a[i]) begin
         cpu.store_byte(a[i], v[i]);
         halt_cycles(n);
         `CHK(n, 2)
         wait_idle();
      end
      foreach (a[i]) begin
         cpu.io_write(IO_ADDR_HIGH, {6'h00, a[i][9:8]});
         cpu.io_write(IO_ADDR_LOW, a[i][7:0]);
         cpu.io_write(IO_CTRL, 8'h01 << CTRL_READ_BIT);
         halt_cycles(n);
         `CHK(n, 4)
         cpu.io_read(IO_DATA, d);
         `CHK(d, v[i])
      end
      $display("test write and read done");
   endtask : t_write_read
   task automatic t_refused();
      cpu.store_byte(10'h007, 8'h11);
      wait_idle();
      cpu.io_write(IO_DATA, 8'h99);
      cpu.io_write(IO_CTRL, 8'h01 << CTRL_WRITE_BIT);
      cpu.io_read(IO_CTRL, d);
      `CHK(d[CTRL_WRITE_BIT], 1'b0)
      cpu.io_write(IO_CTRL, 8'h01 << CTRL_ARM_BIT);
      cpu.io_read(IO_CTRL, d);
      `CHK(d[CTRL_ARM_BIT], 1'b1)
      repeat (6) @(posedge sys_clk);
      cpu.io_read(IO_CTRL, d);
      `CHK(d[CTRL_ARM_BIT], 1'b0)
      cpu.io_write(IO_CTRL, 8'h01 << CTRL_WRITE_BIT);
      cpu.io_read(IO_CTRL, d);
      `CHK(d[CTRL_WRITE_BIT], 1'b0)
      cpu.io_write(IO_CTRL, 8'h01 << CTRL_READ_BIT);
      cpu.io_read(IO_DATA, d);
      `CHK(d, 8'h11)
      $display("test refused writes done");
   endtask : t_refused
   task automatic t_busy();
      cpu.store_byte(10'h005, 8'h3c);
      cpu.io_read(IO_CTRL, d);
      `CHK(d[CTRL_WRITE_BIT], 1'b1)
      cpu.io_write(IO_ADDR_LOW, 8'h77);
      cpu.io_read(IO_ADDR_LOW, d);
      `CHK(d, 8'h05)
      cpu.io_write(IO_DATA, 8'h00);
      cpu.io_write(IO_CTRL, 8'h01 << CTRL_READ_BIT);
      cpu.io_read(IO_DATA, d);
      `CHK(d, 8'h00)
      wait_idle();
      cpu.io_write(IO_CTRL, 8'h01 << CTRL_READ_BIT);
      cpu.io_read(IO_DATA, d);
      `CHK(d, 8'h3c)
      $display("test busy guard done");
   endtask : t_busy
   // Reset for 16 cycles, then the tests in turn
   initial begin
      rst_b = 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_addr_bits();
      t_write_read();
      t_refused();
      t_busy();
      report_and_stop();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(20000 * 50);
      err_count++;
      report_and_stop();
   end
endmodule : eeprom_byte_access_port_tb
